// >>> include/lsq_pkg.sv
// package for the linked positioning sequencer: entry layout, states, timing
`default_nettype none
package lsq_pkg;
    // ---------------------------------------------------------------
    // entry table geometry
    // ---------------------------------------------------------------
    localparam int        ENTRY_NUM   = 16;
    localparam logic [3:0] LAST_ENTRY = 4'hf;
    localparam int        MAX_LINK    = 4;
    localparam int        ACC_W       = 8;
    localparam int        TRQ_W       = 8;
    localparam int        DWELL_W     = 16;
    localparam int        POS_W       = 24;
    // ---------------------------------------------------------------
    // timing: dwell counts in milliseconds
    // ---------------------------------------------------------------
    localparam int        CLK_PERIOD_NS = 10;
    localparam int        DWELL_UNIT_NS = 1000000;
    localparam int        MS_CYCLES     = DWELL_UNIT_NS / CLK_PERIOD_NS;
    localparam int        TICK_W        = 20;
    // ---------------------------------------------------------------
    // entry function and stored entry
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        LSQ_FN_SINGLE,
        LSQ_FN_LINKED,
        LSQ_FN_LINKED_DWELL
    } lsq_func_t;

    typedef struct packed {
        lsq_func_t            func;
        logic                 dir;
        logic [ACC_W-1:0]     accel;
        logic [TRQ_W-1:0]     torque;
        logic [DWELL_W-1:0]   dwell_ms;
    } lsq_entry_t;

    typedef enum logic [1:0] {
        LSQ_IDLE,
        LSQ_RUN,
        LSQ_DWELL,
        LSQ_HOME
    } lsq_state_t;

    // segment command towards the power stage
    typedef struct packed {
        logic                 start;
        logic [3:0]           idx;
        logic                 dir;
        logic [ACC_W-1:0]     accel;
    } lsq_seg_t;
endpackage
`default_nettype wire

// >>> src/lsq_sequencer.sv
// linked positioning sequencer: entry chaining, alarms, limits, homing
`default_nettype none
// Summary of operation
// - linked entry runs straight into the next entry without stopping.
// - chain ends at first single entry; motor stops after it completes.
// - no-stop linked entries of differing direction raise the data alarm.
// - chains of five or more entries raise the data alarm.
// - entry fifteen never links onward to entry zero.
// - no-stop chain keeps the starting entry's acceleration and deceleration.
// - torque limit follows the currently selected entry, also during motion.
// - dwell-linked entry stops, waits its dwell time, then runs next entry.
// - move drops at segment end before dwell, rises as next segment starts.
// - ready drops at move start, returns after last entry; host releases start.
// - sensor homing runs until home sensor rising edge, then sets home.
// - two homing methods only: sensor homing and position preset.
// - sixteen stored entries, chosen by the four select inputs.
// - preset loads command position, ignored while moving or in alarm.
module lsq_sequencer #(
    parameter int MS_CYCLES = lsq_pkg::MS_CYCLES
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic                       entry_select_bit0,
    input  wire logic                       entry_select_bit1,
    input  wire logic                       entry_select_bit2,
    input  wire logic                       entry_select_bit3,
    input  wire logic                       start_in,
    input  wire logic                       home_req_in,
    input  wire logic                       preset_req_in,
    input  wire logic                       home_sensor_in,
    input  wire logic                       alarm_clr_in,
    input  wire logic                       home_method_preset,
    input  wire logic signed [lsq_pkg::POS_W-1:0] preset_value,
    input  wire logic                       entry_wr_en,
    input  wire logic [3:0]                 entry_wr_idx,
    input  wire lsq_pkg::lsq_entry_t        entry_wr_data,
    input  wire logic                       seg_done,
    output lsq_pkg::lsq_seg_t               seg_cmd,
    output logic [lsq_pkg::TRQ_W-1:0]       torque_limit,
    output logic                            ready,
    output logic                            move,
    output logic                            alarm_data,
    output logic                            homing_run,
    output logic                            home_set,
    output logic signed [lsq_pkg::POS_W-1:0] cmd_pos
);
    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_sn;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_sn = rst_sync_q[1];

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0][3:0]                 sel_sync;
        logic [1:0][4:0]                 pin_sync;
        logic [4:0]                      pin_prev;
        lsq_pkg::lsq_entry_t [lsq_pkg::ENTRY_NUM-1:0] tbl;
        lsq_pkg::lsq_state_t             st;
        lsq_pkg::lsq_seg_t               seg;
        logic [lsq_pkg::DWELL_W-1:0]     dwell_cnt;
        logic [lsq_pkg::TICK_W-1:0]      tick_cnt;
        logic [lsq_pkg::TRQ_W-1:0]       torque;
        logic                            ready;
        logic                            move;
        logic                            alarm;
        logic                            homing;
        logic                            home_set;
        logic signed [lsq_pkg::POS_W-1:0] pos;
    } lsq_state_s_t;

    lsq_state_s_t s_q;
    lsq_state_s_t s_d;

    // pin_sync bits: 0 start, 1 home, 2 preset, 3 sensor, 4 alarm clear
    logic [3:0]              sel;
    logic [4:0]              pins;
    logic [4:0]              rise;
    logic [3:0]              walk;
    logic                    chain_open;
    logic                    bad_dir;
    logic                    too_long;
    lsq_pkg::lsq_entry_t     cur;
    logic                    tick;

    assign sel  = s_q.sel_sync[1];
    assign pins = s_q.pin_sync[1];
    assign rise = pins & ~s_q.pin_prev;
    assign cur  = s_q.tbl[s_q.seg.idx];
    assign tick = (s_q.tick_cnt == lsq_pkg::TICK_W'(MS_CYCLES - 1));

    // ---------------------------------------------------------------
    // chain check on the selected entry
    // ---------------------------------------------------------------
    // check at start
    always_comb begin
        walk       = sel;
        chain_open = 1'b1;
        bad_dir    = 1'b0;
        for (int k = 0; k < lsq_pkg::MAX_LINK; k++) begin
            if (chain_open) begin
                if (s_q.tbl[walk].func == lsq_pkg::LSQ_FN_SINGLE ||
                    walk == lsq_pkg::LAST_ENTRY) begin
                    chain_open = 1'b0;
                end else begin
                    if (s_q.tbl[walk].func == lsq_pkg::LSQ_FN_LINKED &&
                        s_q.tbl[walk].dir != s_q.tbl[4'(walk + 4'h1)].dir) begin
                        bad_dir = 1'b1;
                    end
                    walk = 4'(walk + 4'h1);
                end
            end
        end
        too_long = chain_open;
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.sel_sync  = {s_q.sel_sync[0], {entry_select_bit3, entry_select_bit2,
                                           entry_select_bit1, entry_select_bit0}};
        s_d.pin_sync  = {s_q.pin_sync[0], {alarm_clr_in, home_sensor_in,
                                           preset_req_in, home_req_in, start_in}};
        s_d.pin_prev  = pins;
        s_d.seg.start = 1'b0;
        s_d.home_set  = 1'b0;
        s_d.tick_cnt  = tick ? '0 : lsq_pkg::TICK_W'(s_q.tick_cnt + 1'b1);
        if (entry_wr_en && s_q.st == lsq_pkg::LSQ_IDLE) begin
            s_d.tbl[entry_wr_idx] = entry_wr_data;
        end
        s_d.torque = s_q.tbl[sel].torque;
        if (rise[4] && s_q.st == lsq_pkg::LSQ_IDLE) begin
            s_d.alarm = 1'b0;
        end
        case (s_q.st)
            lsq_pkg::LSQ_IDLE: begin
                s_d.ready = !s_d.alarm;
                if (rise[0] && s_q.ready) begin
                    s_d.ready = 1'b0;
                    if (bad_dir || too_long) begin
                        s_d.alarm = 1'b1;
                    end else begin
                        s_d.st        = lsq_pkg::LSQ_RUN;
                        s_d.move      = 1'b1;
                        s_d.seg.start = 1'b1;
                        s_d.seg.idx   = sel;
                        s_d.seg.dir   = s_q.tbl[sel].dir;
                        s_d.seg.accel = s_q.tbl[sel].accel;
                    end
                end else if (rise[1] && s_q.ready && !home_method_preset) begin
                    s_d.st     = lsq_pkg::LSQ_HOME;
                    s_d.ready  = 1'b0;
                    s_d.move   = 1'b1;
                    s_d.homing = 1'b1;
                end else if ((rise[2] || (rise[1] && home_method_preset)) &&
                             !s_q.alarm) begin
                    s_d.pos      = preset_value;
                    s_d.home_set = 1'b1;
                end
            end
            lsq_pkg::LSQ_RUN: begin
                if (seg_done) begin
                    if (cur.func == lsq_pkg::LSQ_FN_SINGLE ||
                        s_q.seg.idx == lsq_pkg::LAST_ENTRY) begin
                        s_d.st    = lsq_pkg::LSQ_IDLE;
                        s_d.move  = 1'b0;
                        s_d.ready = 1'b1;
                    end else if (cur.func == lsq_pkg::LSQ_FN_LINKED) begin
                        s_d.seg.start = 1'b1;
                        s_d.seg.idx   = 4'(s_q.seg.idx + 4'h1);
                        s_d.seg.dir   = s_q.tbl[s_d.seg.idx].dir;
                    end else begin
                        s_d.st        = lsq_pkg::LSQ_DWELL;
                        s_d.move      = 1'b0;
                        s_d.dwell_cnt = cur.dwell_ms;
                        s_d.tick_cnt  = '0;
                    end
                end
            end
            lsq_pkg::LSQ_DWELL: begin
                if (s_q.dwell_cnt == '0) begin
                    s_d.st        = lsq_pkg::LSQ_RUN;
                    s_d.move      = 1'b1;
                    s_d.seg.start = 1'b1;
                    s_d.seg.idx   = 4'(s_q.seg.idx + 4'h1);
                    s_d.seg.dir   = s_q.tbl[s_d.seg.idx].dir;
                    s_d.seg.accel = s_q.tbl[s_d.seg.idx].accel;
                end else if (tick) begin
                    s_d.dwell_cnt = s_q.dwell_cnt - 1'b1;
                end
            end
            lsq_pkg::LSQ_HOME: begin
                if (rise[3]) begin
                    s_d.st       = lsq_pkg::LSQ_IDLE;
                    s_d.move     = 1'b0;
                    s_d.homing   = 1'b0;
                    s_d.ready    = 1'b1;
                    s_d.pos      = '0;
                    s_d.home_set = 1'b1;
                end
            end
            default: begin
                s_d.st = lsq_pkg::LSQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sn) begin
        if (!rst_sn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign seg_cmd      = s_q.seg;
    assign torque_limit = s_q.torque;
    assign ready        = s_q.ready;
    assign move         = s_q.move;
    assign alarm_data   = s_q.alarm;
    assign homing_run   = s_q.homing;
    assign home_set     = s_q.home_set;
    assign cmd_pos      = s_q.pos;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    link_no_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_sn)
        s_q.st == lsq_pkg::LSQ_RUN && seg_done && cur.func == lsq_pkg::LSQ_FN_LINKED &&
        s_q.seg.idx != lsq_pkg::LAST_ENTRY |=> move && seg_cmd.start)
        else $error("linked entry did not continue");
    single_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_sn)
        s_q.st == lsq_pkg::LSQ_RUN && seg_done && cur.func == lsq_pkg::LSQ_FN_SINGLE
        |=> !move && ready)
        else $error("single entry did not end chain");
    chain_alarm_a: assert property (@(posedge sys_clk) disable iff (!rst_sn)
        s_q.st == lsq_pkg::LSQ_IDLE && rise[0] && ready && (bad_dir || too_long)
        |=> alarm_data && !move && !seg_cmd.start)
        else $error("bad chain not refused");
    no_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_sn)
        s_q.st == lsq_pkg::LSQ_RUN && seg_done && s_q.seg.idx == lsq_pkg::LAST_ENTRY
        |=> !seg_cmd.start && ready)
        else $error("chain wrapped past last entry");
    accel_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_sn)
        s_q.st == lsq_pkg::LSQ_RUN && seg_done && cur.func == lsq_pkg::LSQ_FN_LINKED
        |=> $stable(seg_cmd.accel))
        else $error("acceleration changed inside chain");
    torque_live_a: assert property (@(posedge sys_clk) disable iff (!rst_sn)
        1'b1 |=> torque_limit == $past(s_q.tbl[sel].torque))
        else $error("torque limit not from selection");
    dwell_move_a: assert property (@(posedge sys_clk) disable iff (!rst_sn)
        s_q.st == lsq_pkg::LSQ_DWELL && s_d.st == lsq_pkg::LSQ_RUN
        |=> move && seg_cmd.start && !ready)
        else $error("move not raised with dwell restart");
    ready_low_a: assert property (@(posedge sys_clk) disable iff (!rst_sn)
        move |-> !ready)
        else $error("ready high while moving");
    home_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_sn)
        s_q.st == lsq_pkg::LSQ_HOME && rise[3] |=> home_set && cmd_pos == '0 && !move)
        else $error("sensor edge did not set home");
    preset_block_a: assert property (@(posedge sys_clk) disable iff (!rst_sn)
        (move || alarm_data) |=> $stable(cmd_pos) || homing_run || $past(homing_run))
        else $error("preset applied while moving or alarmed");
endmodule
`default_nettype wire

// >>> testbench/lsq_host_model.sv
// host controller and power stage model facing the sequencer
`default_nettype none
module lsq_host_model #(
    parameter int SEG_LEN = 6,
    parameter int SETTLE  = 100
) (
    input  wire logic       sys_clk,
    input  wire logic       ready,
    input  wire logic       seg_start,
    output logic [3:0]      sel,
    output logic            start_in,
    output logic            seg_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial begin
        sel = 4'h0;
        start_in = 1'b0;
        seg_done = 1'b0;
    end
    task automatic pick(input logic [3:0] idx);
        @(posedge sys_clk) #1;
        sel = idx;
    endtask
    // ---------------------------------------------------------------
    // start handshake
    // ---------------------------------------------------------------
    // select, settle, start
    // bench millisecond is ten cycles, so 100 cycles keep the 10 ms hold-off
    task automatic run(input logic [3:0] idx);
        pick(idx);
        repeat (SETTLE) @(posedge sys_clk);
        #1 start_in = 1'b1;
        for (int i = 0; i < 20 && ready !== 1'b0; i++) @(posedge sys_clk);
        #1 start_in = 1'b0;
    endtask
    // ---------------------------------------------------------------
    // power stage: fixed segment length, one done pulse
    // ---------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (seg_start === 1'b1) cnt = SEG_LEN;
        else if (cnt > 0) cnt = cnt - 1;
        #1 seg_done = (cnt == 1);
    end
endmodule
`default_nettype wire

// >>> testbench/lsq_sequencer_tb.sv
// self-checking bench for the linked positioning sequencer
`default_nettype none
module lsq_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic sys_clk = 1'b0, rst_n = 1'b0, home_req_in = 1'b0, preset_req_in = 1'b0;
    logic home_sensor_in = 1'b0, alarm_clr_in = 1'b0, home_method_preset = 1'b0;
    logic entry_wr_en = 1'b0, start_in, seg_done, ready, move, alarm_data;
    logic homing_run, home_set;
    logic [3:0]                       sel;
    logic [3:0]                       entry_wr_idx = 4'h0;
    logic [7:0]                       torque_limit;
    logic signed [23:0]               preset_value = 24'sh000123;
    logic signed [23:0]               cmd_pos;
    lsq_pkg::lsq_entry_t              entry_wr_data = '0;
    lsq_pkg::lsq_seg_t                seg_cmd;
    lsq_pkg::lsq_seg_t                segq[$];
    int st_cyc[$], fall_cyc[$];
    int cyc = 0, mv_bad = 0, hs_n = 0, tests_run = 0, bad_count = 0;
    logic move_q = 1'b0;

    lsq_sequencer #(.MS_CYCLES(MS)) u_lsq_sequencer (
        .sys_clk(sys_clk), .rst_n(rst_n), .entry_select_bit0(sel[0]),
        .entry_select_bit1(sel[1]), .entry_select_bit2(sel[2]),
        .entry_select_bit3(sel[3]), .start_in(start_in), .home_req_in(home_req_in),
        .preset_req_in(preset_req_in), .home_sensor_in(home_sensor_in),
        .alarm_clr_in(alarm_clr_in), .home_method_preset(home_method_preset),
        .preset_value(preset_value), .entry_wr_en(entry_wr_en),
        .entry_wr_idx(entry_wr_idx), .entry_wr_data(entry_wr_data),
        .seg_done(seg_done), .seg_cmd(seg_cmd), .torque_limit(torque_limit),
        .ready(ready), .move(move), .alarm_data(alarm_data),
        .homing_run(homing_run), .home_set(home_set), .cmd_pos(cmd_pos));
    lsq_host_model u_lsq_host_model (.sys_clk(sys_clk), .ready(ready),
        .seg_start(seg_cmd.start), .sel(sel), .start_in(start_in), .seg_done(seg_done));

    always #5 sys_clk = ~sys_clk;
    // ---------------------------------------------------------------
    // monitor: segment starts, move falls, pulses
    // ---------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc++;
        if (seg_cmd.start === 1'b1) begin
            segq.push_back(seg_cmd);
            st_cyc.push_back(cyc);
            // move rises with the segment start
            if (move !== 1'b1) mv_bad++;
        end
        if (move === 1'b1 && ready !== 1'b0) mv_bad++;
        if (move_q === 1'b1 && move === 1'b0) fall_cyc.push_back(cyc);
        if (home_set === 1'b1) hs_n++;
        move_q <= move;
    end
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // torque is 8'h10 plus index, so selection shows in torque_limit
    task automatic wr(input logic [3:0] i, input lsq_pkg::lsq_func_t f, input logic d,
                      input logic [7:0] a, input logic [15:0] w);
        tick(1);
        entry_wr_en = 1'b1;
        entry_wr_idx = i;
        entry_wr_data = '{f, d, a, 8'h10 + {4'h0, i}, w};
        tick(1);
        entry_wr_en = 1'b0;
    endtask
    task automatic wait_end();
        for (int i = 0; i < 600 && ready !== 1'b1 && alarm_data !== 1'b1; i++)
            @(posedge sys_clk);
        tick(2);
    endtask
    task automatic go(input logic [3:0] idx);
        segq.delete();
        st_cyc.delete();
        fall_cyc.delete();
        u_lsq_host_model.run(idx);
        wait_end();
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(5);
        s = 1'b0;
        tick(5);
    endtask
    task automatic conclude();
        $display("counts: tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_chains();
        wr(4'h2, lsq_pkg::LSQ_FN_LINKED, 1'b1, 8'h31, 16'h0);
        wr(4'h3, lsq_pkg::LSQ_FN_LINKED, 1'b1, 8'h32, 16'h0);
        wr(4'h4, lsq_pkg::LSQ_FN_SINGLE, 1'b1, 8'h33, 16'h0);
        go(4'h2);
        chk("seg count", segq.size(), 3);
        chk("last idx", segq[2].idx, 4'h4);
        chk("kept accel", segq[2].accel, 8'h31);
        chk("move falls", fall_cyc.size(), 1);
        chk("ready back", ready, 1'b1);
        wr(4'h4, lsq_pkg::LSQ_FN_LINKED, 1'b1, 8'h33, 16'h0);
        wr(4'h5, lsq_pkg::LSQ_FN_LINKED, 1'b1, 8'h34, 16'h0);
        wr(4'h6, lsq_pkg::LSQ_FN_SINGLE, 1'b1, 8'h35, 16'h0);
        go(4'h2);
        chk("five chain alarm", alarm_data, 1'b1);
        chk("five chain segs", segq.size(), 0);
        pulse(alarm_clr_in);
        go(4'h3);
        chk("four chain segs", segq.size(), 4);
        $display("test chains done");
    endtask
    task automatic t_dir_wrap();
        wr(4'h7, lsq_pkg::LSQ_FN_LINKED, 1'b0, 8'h01, 16'h0);
        wr(4'h8, lsq_pkg::LSQ_FN_SINGLE, 1'b1, 8'h02, 16'h0);
        go(4'h7);
        chk("dir alarm", alarm_data, 1'b1);
        chk("dir segs", segq.size(), 0);
        pulse(preset_req_in);
        chk("preset in alarm", cmd_pos, 24'h0);
        pulse(alarm_clr_in);
        chk("alarm cleared", {alarm_data, ready}, 2'b01);
        wr(4'hf, lsq_pkg::LSQ_FN_LINKED, 1'b0, 8'h05, 16'h0);
        go(4'hf);
        chk("no wrap segs", segq.size(), 1);
        chk("entry 15 idx", segq[0].idx, 4'hf);
        $display("test direction and wrap done");
    endtask
    task automatic t_dwell();
        wr(4'h9, lsq_pkg::LSQ_FN_LINKED_DWELL, 1'b0, 8'h41, 16'h2);
        wr(4'ha, lsq_pkg::LSQ_FN_SINGLE, 1'b1, 8'h42, 16'h0);
        wr(4'hc, lsq_pkg::LSQ_FN_SINGLE, 1'b0, 8'h00, 16'h0);
        segq.delete();
        st_cyc.delete();
        fall_cyc.delete();
        u_lsq_host_model.run(4'h9);
        u_lsq_host_model.pick(4'hc);
        tick(4);
        chk("still moving", move, 1'b1);
        chk("torque moving", torque_limit, 8'h1c);
        wait_end();
        chk("dwell segs", segq.size(), 2);
        chk("dwell accel", segq[1].accel, 8'h42);
        chk("dwell dir", segq[1].dir, 1'b1);
        chk("dwell gap", (st_cyc[1] - fall_cyc[0]) inside {[MS : 2 * MS + 2]}, 1'b1);
        chk("move fall count", fall_cyc.size(), 2);
        chk("move at start", mv_bad, 0);
        $display("test dwell done");
    endtask
    task automatic t_home();
        hs_n = 0;
        pulse(preset_req_in);
        chk("preset pos", cmd_pos, 24'h000123);
        home_method_preset = 1'b1;
        preset_value = 24'sh7ffff0;
        pulse(home_req_in);
        chk("home preset pos", cmd_pos, 24'h7ffff0);
        home_method_preset = 1'b0;
        pulse(home_req_in);
        chk("homing", {homing_run, move, ready}, 3'b110);
        pulse(preset_req_in);
        chk("preset moving", cmd_pos, 24'h7ffff0);
        pulse(home_sensor_in);
        chk("home done", {homing_run, move, ready}, 3'b001);
        chk("home pos", cmd_pos, 24'h0);
        chk("home pulses", hs_n, 3);
        $display("test homing done");
    endtask
    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        tick(6);
        rst_n = 1'b1;
        tick(8);
        t_chains();
        t_dir_wrap();
        t_dwell();
        t_home();
        conclude();
    end
    initial begin
        #200us;
        bad_count++;
        conclude();
    end
endmodule
`default_nettype wire
